// File: rtl/ehcc_command_control.sv
// command register lower fields, soft reset and run/stop control
`timescale 1ns/1ps
`default_nettype none
module ehcc_command_control
  import ehcc_pkg::*;
(
  // clock and chip reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // command register write/read port
  input  wire logic                  cmd_wr,
  input  wire logic [31:0]           cmd_wdata,
  output logic      [31:0]           host_command_reg,
  output logic      [31:0]           host_status_reg,
  // capability strap
  input  wire logic                  programmable_frame_list_cap,
  // schedule engine side
  input  wire logic                  pipeline_busy,
  input  wire logic [FRINDEX_W-1:0]  frame_index,
  output logic                       periodic_fetch_en,
  output logic      [LIST_IDX_W-1:0] list_index,
  output logic                       controller_halted,
  // reset effects on core and ports
  output logic                       core_reset,
  output logic                       abort_transaction,
  output logic                       port_owner_companion,
  output logic                       bus_reset_drive
);
  logic       run_stop;
  logic       periodic_sched_enable;
  logic [1:0] frame_list_size;
  logic       controller_soft_reset;
  logic [3:0] rst_cnt;
  logic       cap_sync1;
  logic       cap;
  ehcc_state_t state;

  // capability strap crosses in through two flops
  always_ff @(posedge core_clk) begin
    cap_sync1 <= programmable_frame_list_cap;
    cap       <= cap_sync1;
  end

  // soft reset sequencer; zero writes cannot end it early
  always_ff @(posedge core_clk) begin
    if (srst) begin
      controller_soft_reset <= 1'b0;
      rst_cnt               <= 4'h0;
    end else if (controller_soft_reset) begin
      if (rst_cnt == RESET_CYCLES - 4'h1) begin
        controller_soft_reset <= 1'b0;
        rst_cnt               <= 4'h0;
      end else begin
        rst_cnt <= rst_cnt + 4'h1;
      end
    end else if (cmd_wr && cmd_wdata[CMD_RESET_BIT]) begin
      controller_soft_reset <= 1'b1;
      rst_cnt               <= 4'h0;
    end
  end

  // operational fields; soft reset restores defaults
  always_ff @(posedge core_clk) begin
    if (srst || controller_soft_reset) begin
      run_stop              <= 1'b0;
      periodic_sched_enable <= 1'b0;
      frame_list_size       <= FLS_1024;
    end else if (cmd_wr) begin
      run_stop              <= cmd_wdata[CMD_RUN_BIT];
      periodic_sched_enable <= cmd_wdata[CMD_PSE_BIT];
      // size only moves when capable and code is legal
      if (cap && cmd_wdata[CMD_FLS_HI:CMD_FLS_LO] != FLS_RSVD) begin
        frame_list_size <= cmd_wdata[CMD_FLS_HI:CMD_FLS_LO];
      end
    end
  end

  // run/stop machine: drain pipeline before halting
  // the drain state has no time limit; a stuck engine keeps the
  // controller out of halted, which is safer than dropping work
  always_ff @(posedge core_clk) begin
    if (srst || controller_soft_reset) begin
      state <= EHCC_HALTED;
    end else begin
      unique case (state)
        EHCC_HALTED:   if (run_stop) state <= EHCC_RUNNING;
        EHCC_RUNNING:  if (!run_stop) state <= EHCC_DRAINING;
        EHCC_DRAINING: if (!pipeline_busy) state <= EHCC_HALTED;
        // the fourth code of the state word is unused; fall back to halted
        default:       state <= EHCC_HALTED;
      endcase
    end
  end

  // halted is zero whenever run is set
  assign controller_halted = (state == EHCC_HALTED) && !run_stop;
  assign periodic_fetch_en = periodic_sched_enable && (state == EHCC_RUNNING);
  assign core_reset           = controller_soft_reset;
  assign abort_transaction    = controller_soft_reset;
  assign port_owner_companion = controller_soft_reset;
  assign bus_reset_drive      = 1'b0;

  // register read views
  always_comb begin
    host_command_reg = 32'h0;
    host_command_reg[CMD_RUN_BIT]           = run_stop;
    host_command_reg[CMD_RESET_BIT]         = controller_soft_reset;
    host_command_reg[CMD_FLS_HI:CMD_FLS_LO] = frame_list_size;
    host_command_reg[CMD_PSE_BIT]           = periodic_sched_enable;
    host_status_reg = 32'h0;
    host_status_reg[STS_HALT_BIT]           = controller_halted;
  end

  ehcc_index_sel u_index_sel (
    .frame_index     (frame_index),
    .frame_list_size (frame_list_size),
    .list_index      (list_index)
  );

  // checks
  // every property is sampled on the core clock; chip reset disables all but AST_HALT_AFTER_SRST,
  // and AST_STOP_DRAINS, AST_RUN_LEAVES_HALT and AST_DRAIN_HOLDS also pause while a soft reset is in progress
  // stop request seen while the machine is still running
  sequence s_stop_req;
    $fell(run_stop) && (state == EHCC_RUNNING);
  endsequence
  // engine reports nothing left in flight
  sequence s_pipe_idle;
    !pipeline_busy;
  endsequence
  // run request seen while the machine is halted
  sequence s_run_req;
    $rose(run_stop) && (state == EHCC_HALTED);
  endsequence
  AST_HALT_AFTER_DRAIN: assert property (@(posedge core_clk) disable iff (srst)
    (state == EHCC_DRAINING && pipeline_busy) |-> !controller_halted)
    else $error("halted while pipeline busy");
  AST_NOT_HALTED_RUN: assert property (@(posedge core_clk) disable iff (srst)
    run_stop |-> !controller_halted) else $error("halted while running");
  AST_STOP_DRAINS: assert property (@(posedge core_clk) disable iff (srst || controller_soft_reset)
    s_stop_req ##1 s_pipe_idle |=> controller_halted)
    else $error("stop did not drain");
  AST_RST_SELF_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    $rose(controller_soft_reset) |-> controller_soft_reset [*8] ##1 !controller_soft_reset)
    else $error("soft reset length wrong");
  AST_RST_DEFAULTS: assert property (@(posedge core_clk) disable iff (srst)
    $past(controller_soft_reset) |-> !run_stop && frame_list_size == FLS_1024)
    else $error("defaults not restored");
  AST_FLS_NO_RSVD: assert property (@(posedge core_clk) disable iff (srst)
    frame_list_size != FLS_RSVD) else $error("reserved size in effect");
  AST_FLS_LOCKED: assert property (@(posedge core_clk) disable iff (srst)
    !cap |=> $stable(frame_list_size) || frame_list_size == FLS_1024)
    else $error("size changed without capability");
  AST_PERIODIC_GATE: assert property (@(posedge core_clk) disable iff (srst)
    !periodic_sched_enable |-> !periodic_fetch_en) else $error("periodic fetched while off");
  AST_NO_BUS_RESET: assert property (@(posedge core_clk) disable iff (srst)
    controller_soft_reset |-> abort_transaction && !bus_reset_drive && port_owner_companion)
    else $error("soft reset effects wrong");
  // chip reset leaves the controller halted
  AST_HALT_AFTER_SRST: assert property (@(posedge core_clk)
    $past(srst) |-> controller_halted)
    else $error("not halted after chip reset");
  // periodic fetching only while running
  AST_FETCH_NEEDS_RUN: assert property (@(posedge core_clk) disable iff (srst)
    periodic_fetch_en |-> (state == EHCC_RUNNING))
    else $error("periodic fetch while not running");
  // a write during soft reset cannot set the run bit
  AST_RST_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
    (controller_soft_reset && cmd_wr) |=> !run_stop)
    else $error("write taken during soft reset");
  // reset counter never passes its end value
  AST_RST_CNT_RANGE: assert property (@(posedge core_clk) disable iff (srst)
    rst_cnt < RESET_CYCLES)
    else $error("reset counter out of range");
  // halted flag only in the halted state
  AST_HALT_MATCHES_STATE: assert property (@(posedge core_clk) disable iff (srst)
    controller_halted |-> (state == EHCC_HALTED))
    else $error("halted outside halted state");
  // status view mirrors the halted flag
  AST_STATUS_VIEW: assert property (@(posedge core_clk) disable iff (srst)
    host_status_reg[STS_HALT_BIT] == controller_halted)
    else $error("status view wrong");
  // command view shows the soft reset bit while it runs
  AST_CMD_VIEW_RESET: assert property (@(posedge core_clk) disable iff (srst)
    host_command_reg[CMD_RESET_BIT] == controller_soft_reset)
    else $error("reset bit view wrong");
  // small list clears the two upper index bits
  AST_INDEX_256: assert property (@(posedge core_clk) disable iff (srst)
    (frame_list_size == FLS_256) |-> (list_index[LIST_IDX_W-1 -: 2] == 2'h0))
    else $error("index too wide for small list");
  // full list passes the counter bits unchanged
  AST_INDEX_1024: assert property (@(posedge core_clk) disable iff (srst)
    (frame_list_size == FLS_1024) |-> (list_index == frame_index[IDX_LSB +: LIST_IDX_W]))
    else $error("full list index wrong");
  // run request leaves halted at the next edge
  AST_RUN_LEAVES_HALT: assert property (@(posedge core_clk)
    disable iff (srst || controller_soft_reset)
    s_run_req |=> (state == EHCC_RUNNING))
    else $error("run did not start");
  // draining persists while work is in flight
  AST_DRAIN_HOLDS: assert property (@(posedge core_clk)
    disable iff (srst || controller_soft_reset)
    (state == EHCC_DRAINING && pipeline_busy) |=> (state == EHCC_DRAINING))
    else $error("drain ended early");
  // size only moves with capability, or back to its default
  AST_SIZE_NEEDS_CAP: assert property (@(posedge core_clk) disable iff (srst)
    $changed(frame_list_size) |-> $past(cap) || frame_list_size == FLS_1024)
    else $error("size moved without capability");
endmodule
`default_nettype wire

// File: rtl/ehcc_index_sel.sv
// frame list index selection from the frame index counter
`timescale 1ns/1ps
`default_nettype none
module ehcc_index_sel
  import ehcc_pkg::*;
(
  // inputs
  input  wire logic [FRINDEX_W-1:0]  frame_index,
  input  wire logic [1:0]            frame_list_size,
  // output
  output logic      [LIST_IDX_W-1:0] list_index
);
  logic [LIST_IDX_W-1:0] raw;
  assign raw = frame_index[IDX_LSB +: LIST_IDX_W];
  // upper index bits masked for smaller lists
  always_comb begin
    unique case (frame_list_size)
      FLS_512: list_index = raw & 10'h1ff;
      FLS_256: list_index = raw & 10'h0ff;
      default: list_index = raw;
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/ehcc_pkg.sv
// constants and types of the host command control block
package ehcc_pkg;
  localparam int       CMD_RUN_BIT      = 0;
  localparam int       CMD_RESET_BIT    = 1;
  localparam int       CMD_FLS_LO       = 2;
  localparam int       CMD_FLS_HI       = 3;
  localparam int       CMD_PSE_BIT      = 4;
  localparam int       STS_HALT_BIT     = 12;
  localparam logic [1:0] FLS_1024       = 2'h0;
  localparam logic [1:0] FLS_512        = 2'h1;
  localparam logic [1:0] FLS_256        = 2'h2;
  localparam logic [1:0] FLS_RSVD       = 2'h3;
  localparam int       FRINDEX_W        = 14;
  localparam int       LIST_IDX_W       = 10;
  // frame index bits 12:3 address a 1024-entry list
  localparam int       IDX_LSB          = 3;
  // soft reset length in cycles (chosen)
  localparam logic [3:0] RESET_CYCLES   = 4'h8;
  typedef enum logic [1:0] {EHCC_HALTED, EHCC_RUNNING, EHCC_DRAINING} ehcc_state_t;
endpackage

// File: test/ehcc_command_control_bench.sv
// self-checking bench for the command control block
`timescale 1ns/1ps
`default_nettype none
module ehcc_command_control_bench;
  import ehcc_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  srst     = 1'b1;
  logic                  cmd_wr   = 1'b0;
  logic                  cap      = 1'b0;
  logic                  busy     = 1'b0;
  logic [31:0]           wd       = 32'h0;
  logic [FRINDEX_W-1:0]  fi       = 14'h1fff;
  logic [31:0]           cmd;
  logic [31:0]           sts;
  logic [LIST_IDX_W-1:0] idx;
  logic                  fetch, halted, crst, abrt, owner, busrst;
  int                    mismatches = 0;
  int                    checks     = 0;
  int                    n;
  logic [1:0]            e;
  always #5 core_clk = ~core_clk;
  ehcc_command_control i_dut (.core_clk(core_clk), .srst(srst), .cmd_wr(cmd_wr),
    .cmd_wdata(wd), .host_command_reg(cmd), .host_status_reg(sts),
    .programmable_frame_list_cap(cap), .pipeline_busy(busy), .frame_index(fi),
    .periodic_fetch_en(fetch), .list_index(idx), .controller_halted(halted),
    .core_reset(crst), .abort_transaction(abrt), .port_owner_companion(owner),
    .bus_reset_drive(busrst));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe; values settle one step after the taking edge
  task automatic wr(input logic [31:0] v);
    @(posedge core_clk);
    cmd_wr <= 1'b1;
    wd     <= v;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog sized well above the forty or so cycles the tests need
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    check("cmd reset", cmd, 32'h0);
    check("halted reset", {sts[STS_HALT_BIT], halted}, 32'h3);
    check("reset outs", {crst, abrt, owner, busrst}, 32'h0);
    $display("test reset values done");
    wr(32'h4);
    check("size locked", cmd[3:2], FLS_1024);
    @(posedge core_clk);
    cap <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      wr(32'(i) << CMD_FLS_LO);
      e = (i == 3) ? FLS_256 : 2'(i);
      check("size", cmd[3:2], e);
      check("list index", idx, 10'h3ff >> e);
    end
    $display("test frame list size done");
    busy <= 1'b1;
    wr(32'h1);
    check("fetch off", {fetch, halted, sts[STS_HALT_BIT]}, 32'h0);
    wr(32'h11);
    check("fetch on", fetch, 1'b1);
    wr(32'h10);
    repeat (3) @(posedge core_clk);
    #1;
    check("drain halted", halted, 1'b0);
    busy <= 1'b0;
    n = 0;
    while (halted !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("stopped", {sts[STS_HALT_BIT], halted, fetch}, 32'h6);
    // idle pipeline: stop halts two edges after the write is taken
    wr(32'h1);
    check("run again", halted, 1'b0);
    wr(32'h0);
    check("stop pending", halted, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    check("idle stop", halted, 1'b1);
    $display("test run stop done");
    wr(32'h12);
    check("reset effects", {crst, abrt, owner, busrst}, 32'he);
    // a zero write mid reset must not cut it short
    wr(32'h0);
    // two reset cycles have passed since the taking edge
    n = 2;
    while (cmd[CMD_RESET_BIT] === 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("reset length", n, 32'(RESET_CYCLES));
    check("after reset", {cmd[4:0], crst, halted}, 32'h1);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
